// [hw/supply_ctrl_defs.svh]
`ifndef SUPPLY_CTRL_DEFS_SVH
`define SUPPLY_CTRL_DEFS_SVH

// Register offsets on the byte access port.
`define HWA_OFFSET        7'h02
`define WDC_OFFSET        7'h03
`define BUSA_OFFSET       7'h04

// Hardware control register layout.
`define HWA_SRST_BIT      6
`define HWA_FO_BIT        5
`define HWA_CP_BIT        2
`define HWA_CNT_BIT       0
`define HWA_WMASK         8'h65
`define HWA_POR           8'h00
`define HWA_RESTART_KEEP  8'h45

// Watchdog control register layout.
`define WDC_PARITY_BIT    7
`define WDC_STOPOFF_BIT   6
`define WDC_WIN_BIT       5
`define WDC_WAKE_BIT      4
`define WDC_PERIOD_MSB    2
`define WDC_WMASK         8'hf7
`define WDC_POR           8'h14
`define WDC_RESTART_KEEP  8'hb0
`define WDC_RESTART_SET   8'h04

// Bus control register layout.
`define BUSA_MODE_MSB     1
`define BUSA_WMASK        8'h03
`define BUSA_POR          8'h00
`define BUSA_DEV_POR      8'h03
`define BUSA_FAILSAFE     8'h01

`endif

// [hw/supply_ctrl_pkg.sv]
package supply_ctrl_pkg;

    // Transceiver states selected by the bus mode field.
    typedef enum logic [1:0] {
        CAN_OFF     = 2'h0,
        CAN_WAKE    = 2'h1,
        CAN_RX_ONLY = 2'h2,
        CAN_NORMAL  = 2'h3
    } can_mode_t;

    // Start-up sequence: power-on values are loaded once after reset release.
    typedef enum logic {
        ST_POWER_UP = 1'b0,
        ST_RUN      = 1'b1
    } init_state_t;

endpackage

// [hw/ctrl_byte_reg.sv]
`timescale 1ns/10ps

// One 8-bit control byte with a per-bit write mask and a hardware load.
module ctrl_byte_reg #(
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst,
    // Software write.
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_mask,
    input  wire logic [7:0] wdata,
    // Hardware load, which wins over a write in the same cycle.
    input  wire logic       hw_load,
    input  wire logic [7:0] hw_value,
    // Stored value.
    output logic      [7:0] q_r
);

    logic [7:0] q_nxt;

    // A write only changes the bits that its mask opens.
    always_comb begin
        q_nxt = q_r;
        if (hw_load) begin
            q_nxt = hw_value;
        end else if (wr_en) begin
            q_nxt = (q_r & ~wr_mask) | (wdata & wr_mask);
        end
    end

    // Storage.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q_r <= RESET_VALUE;
        end else begin
            q_r <= q_nxt;
        end
    end

endmodule // ctrl_byte_reg

// [hw/supply_ctrl_regs.sv]
`timescale 1ns/10ps
`include "supply_ctrl_defs.svh"

module supply_ctrl_regs
    import supply_ctrl_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst,
    // Byte access from the serial frame logic.
    input  wire logic       acc_en,
    input  wire logic       acc_write,
    input  wire logic [6:0] acc_addr,
    input  wire logic [7:0] acc_wdata,
    // Mode events, one-cycle pulses.
    input  wire logic       soft_reset,
    input  wire logic       restart_entry,
    input  wire logic       failsafe_entry,
    input  wire logic [1:0] restart_can_mode,
    // Device conditions, levels.
    input  wire logic       development_mode,
    input  wire logic       lock_a,
    input  wire logic       lock_b,
    input  wire logic       failure_active,
    input  wire logic       pin_is_fail_output,
    input  wire logic       stop_mode,
    input  wire logic       can_wake_in_stop,
    // Read data and access status.
    output logic [7:0]      rdata_r,
    output logic            parity_error_r,
    // Controls to the rest of the chip.
    output logic            reset_pull_r,
    output logic            fail_output_r,
    output logic            charge_pump_enable_r,
    output logic            watchdog_fail_count_select_r,
    output logic            wdog_off_in_stop_r,
    output logic            window_type_select_r,
    output logic            wdog_wake_start_r,
    output logic [2:0]      watchdog_period_select_r,
    output can_mode_t       can_mode_r
);

    init_state_t state_r;
    init_state_t state_nxt;
    logic [7:0]  hwa_q;
    logic [7:0]  wdc_q;
    logic [7:0]  busa_q;
    logic        hwa_sel;
    logic        wdc_sel;
    logic        busa_sel;
    logic        wr_hit;
    logic        wdc_parity_ok;
    logic [7:0]  hwa_mask;
    logic        hwa_load;
    logic        wdc_load;
    logic        busa_load;
    logic [7:0]  hwa_value;
    logic [7:0]  wdc_value;
    logic [7:0]  busa_value;
    logic [7:0]  busa_por;
    logic [7:0]  hwa_srst;
    logic [7:0]  rdata_nxt;
    logic        parity_error_nxt;
    logic        reset_pull_nxt;
    logic        fail_output_nxt;
    logic        wdog_off_nxt;
    logic        wdog_wake_nxt;

    // Power-on values are loaded in the first cycle after reset release.
    always_comb begin
        state_nxt = ST_RUN;
        case (state_r)
            ST_POWER_UP: state_nxt = ST_RUN;
            ST_RUN:      state_nxt = ST_RUN;
            default:     state_nxt = ST_RUN;
        endcase
    end

    // Start-up state register.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_POWER_UP;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Address decode for the three control bytes.
    assign hwa_sel  = (acc_addr == `HWA_OFFSET);
    assign wdc_sel  = (acc_addr == `WDC_OFFSET);
    assign busa_sel = (acc_addr == `BUSA_OFFSET);
    assign wr_hit   = acc_en & acc_write;

    // The watchdog byte is taken only with an even count of ones.
    assign wdc_parity_ok = ~(^acc_wdata);

    // Locked bits drop out of the write mask; lock B is held outside until power-down.
    always_comb begin
        hwa_mask = `HWA_WMASK;
        if (lock_b) begin
            hwa_mask[`HWA_SRST_BIT] = 1'b0;
        end
        if (lock_a) begin
            hwa_mask[`HWA_CP_BIT] = 1'b0;
        end
    end

    // Soft-reset value of the hardware byte keeps the locked bits.
    always_comb begin
        hwa_srst = `HWA_POR;
        if (lock_b) begin
            hwa_srst[`HWA_SRST_BIT] = hwa_q[`HWA_SRST_BIT];
        end
        if (lock_a) begin
            hwa_srst[`HWA_CP_BIT] = hwa_q[`HWA_CP_BIT];
        end
    end

    // Development mode starts the transceiver in normal communication.
    assign busa_por = development_mode ? `BUSA_DEV_POR : `BUSA_POR;

    // Hardware loads of the hardware control byte: restart wins over soft reset.
    always_comb begin
        hwa_load  = 1'b0;
        hwa_value = hwa_q;
        if (state_r == ST_POWER_UP) begin
            hwa_load  = 1'b1;
            hwa_value = `HWA_POR;
        end else if (restart_entry) begin
            hwa_load  = 1'b1;
            hwa_value = hwa_q & `HWA_RESTART_KEEP;
        end else if (soft_reset) begin
            hwa_load  = 1'b1;
            hwa_value = hwa_srst;
        end
    end

    // Hardware loads of the watchdog byte.
    always_comb begin
        wdc_load  = 1'b0;
        wdc_value = wdc_q;
        if (state_r == ST_POWER_UP) begin
            wdc_load  = 1'b1;
            wdc_value = `WDC_POR;
        end else if (restart_entry) begin
            wdc_load  = 1'b1;
            wdc_value = (wdc_q & `WDC_RESTART_KEEP) | `WDC_RESTART_SET;
        end else if (soft_reset) begin
            wdc_load  = 1'b1;
            wdc_value = `WDC_POR;
        end
    end

    // Hardware loads of the bus byte: fail-safe wins over every cause but the power-up load.
    always_comb begin
        busa_load  = 1'b0;
        busa_value = busa_q;
        if (state_r == ST_POWER_UP) begin
            busa_load  = 1'b1;
            busa_value = busa_por;
        end else if (failsafe_entry) begin
            busa_load  = 1'b1;
            busa_value = `BUSA_FAILSAFE;
        end else if (restart_entry) begin
            busa_load  = 1'b1;
            busa_value = {6'h00, restart_can_mode};
        end else if (soft_reset) begin
            busa_load  = 1'b1;
            busa_value = busa_por;
        end
    end

    // Hardware control byte.
    ctrl_byte_reg #(
        .RESET_VALUE (`HWA_POR)
    ) u_hwa (
        .clk      (clk),
        .rst      (rst),
        .wr_en    (wr_hit & hwa_sel),
        .wr_mask  (hwa_mask),
        .wdata    (acc_wdata),
        .hw_load  (hwa_load),
        .hw_value (hwa_value),
        .q_r      (hwa_q)
    );

    // Watchdog control byte; a write with odd parity is dropped.
    ctrl_byte_reg #(
        .RESET_VALUE (`WDC_POR)
    ) u_wdc (
        .clk      (clk),
        .rst      (rst),
        .wr_en    (wr_hit & wdc_sel & wdc_parity_ok),
        .wr_mask  (`WDC_WMASK),
        .wdata    (acc_wdata),
        .hw_load  (wdc_load),
        .hw_value (wdc_value),
        .q_r      (wdc_q)
    );

    // Bus control byte.
    ctrl_byte_reg #(
        .RESET_VALUE (`BUSA_POR)
    ) u_busa (
        .clk      (clk),
        .rst      (rst),
        .wr_en    (wr_hit & busa_sel),
        .wr_mask  (`BUSA_WMASK),
        .wdata    (acc_wdata),
        .hw_load  (busa_load),
        .hw_value (busa_value),
        .q_r      (busa_q)
    );

    // Every access returns the content held before it; reserved bits are never stored.
    always_comb begin
        rdata_nxt = rdata_r;
        if (acc_en) begin
            rdata_nxt = 8'h00;
            if (hwa_sel) begin
                rdata_nxt = hwa_q & `HWA_WMASK;
            end else if (wdc_sel) begin
                rdata_nxt = wdc_q & `WDC_WMASK;
            end else if (busa_sel) begin
                rdata_nxt = busa_q & `BUSA_WMASK;
            end
        end
    end

    // Status and control outputs derived from the stored bytes, the access, the mode events and the device conditions.
    always_comb begin
        parity_error_nxt = wr_hit & wdc_sel & ~wdc_parity_ok;
        reset_pull_nxt   = soft_reset & ~hwa_q[`HWA_SRST_BIT];
        fail_output_nxt  = pin_is_fail_output & (hwa_q[`HWA_FO_BIT] | failure_active);
        wdog_off_nxt     = stop_mode & wdc_q[`WDC_STOPOFF_BIT];
        wdog_wake_nxt    = can_wake_in_stop & wdc_q[`WDC_WAKE_BIT];
    end

    // Output registers.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_r                      <= 8'h00;
            parity_error_r               <= 1'b0;
            reset_pull_r                 <= 1'b0;
            fail_output_r                <= 1'b0;
            charge_pump_enable_r         <= 1'b0;
            watchdog_fail_count_select_r <= 1'b0;
            wdog_off_in_stop_r           <= 1'b0;
            window_type_select_r         <= 1'b0;
            wdog_wake_start_r            <= 1'b0;
            watchdog_period_select_r     <= 3'h0;
            can_mode_r                   <= CAN_OFF;
        end else begin
            rdata_r                      <= rdata_nxt;
            parity_error_r               <= parity_error_nxt;
            reset_pull_r                 <= reset_pull_nxt;
            fail_output_r                <= fail_output_nxt;
            charge_pump_enable_r         <= hwa_q[`HWA_CP_BIT];
            watchdog_fail_count_select_r <= hwa_q[`HWA_CNT_BIT];
            wdog_off_in_stop_r           <= wdog_off_nxt;
            window_type_select_r         <= wdc_q[`WDC_WIN_BIT];
            wdog_wake_start_r            <= wdog_wake_nxt;
            watchdog_period_select_r     <= wdc_q[`WDC_PERIOD_MSB:0];
            can_mode_r                   <= can_mode_t'(busa_q[`BUSA_MODE_MSB:0]);
        end
    end

endmodule // supply_ctrl_regs

// [verif/supply_ctrl_regs_asserts.sv]
`timescale 1ns/10ps

// Watches the control register bank from its ports only.
module supply_ctrl_regs_chk
    import supply_ctrl_pkg::*;
(
    // Clock, reset and stimulus.
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       acc_en,
    input wire logic       acc_write,
    input wire logic [6:0] acc_addr,
    input wire logic [7:0] acc_wdata,
    input wire logic       soft_reset,
    input wire logic       restart_entry,
    input wire logic       failsafe_entry,
    input wire logic [1:0] restart_can_mode,
    input wire logic       failure_active,
    input wire logic       pin_is_fail_output,
    // Design outputs.
    input wire logic [7:0] rdata_r,
    input wire logic       parity_error_r,
    input wire logic       reset_pull_r,
    input wire logic       fail_output_r,
    input wire logic       window_type_select_r,
    input wire logic [2:0] watchdog_period_select_r,
    input wire can_mode_t  can_mode_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic wd_wr;

    // A write aimed at the watchdog byte.
    assign wd_wr = acc_en && acc_write && acc_addr == 7'h03;

    property p_rsv_zero;
        $past(acc_en) && $past(acc_addr) == 7'h02 |-> (rdata_r & 8'h9a) == 8'h00;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bit read as one");
    property p_pull_cause;
        !soft_reset |=> !reset_pull_r;
    endproperty
    a_pull_cause: assert property (p_pull_cause) else $error("reset pull without soft reset");
    property p_fail_pin;
        fail_output_r |-> $past(pin_is_fail_output);
    endproperty
    a_fail_pin: assert property (p_fail_pin) else $error("fail output on a non-fail pin");
    property p_fail_hold;
        failure_active && pin_is_fail_output && !$past(rst) |=> fail_output_r;
    endproperty
    a_fail_hold: assert property (p_fail_hold) else $error("failure did not hold fail output");
    property p_restart_wd;
        restart_entry && !$past(rst) |-> ##2 watchdog_period_select_r == 3'h4;
    endproperty
    a_restart_wd: assert property (p_restart_wd) else $error("restart period not 100");
    property p_failsafe_bus;
        failsafe_entry && !$past(rst) |-> ##2 can_mode_r == CAN_WAKE;
    endproperty
    a_failsafe_bus: assert property (p_failsafe_bus) else $error("fail-safe bus mode wrong");
    property p_restart_bus;
        restart_entry && !failsafe_entry && !$past(rst) |-> ##2 can_mode_r == can_mode_t'($past(restart_can_mode, 2));
    endproperty
    a_restart_bus: assert property (p_restart_bus) else $error("restart bus mode wrong");
    property p_wd_write;
        wd_wr && !(^acc_wdata) && !restart_entry && !soft_reset && !$past(rst)
            |-> ##2 window_type_select_r == $past(acc_wdata[5], 2);
    endproperty
    a_wd_write: assert property (p_wd_write) else $error("watchdog type not written");
    property p_parity;
        wd_wr && ^acc_wdata && !restart_entry && !soft_reset && !$past(rst) |=> parity_error_r;
    endproperty
    a_parity: assert property (p_parity) else $error("odd parity not flagged");

    // Main scenarios reached.
    c_restart: cover property (restart_entry);
    c_failsafe: cover property (failsafe_entry);
    c_parity: cover property (parity_error_r);
endmodule // supply_ctrl_regs_chk

bind supply_ctrl_regs supply_ctrl_regs_chk u_chk (.clk, .rst, .acc_en, .acc_write, .acc_addr, .acc_wdata,
    .soft_reset, .restart_entry, .failsafe_entry, .restart_can_mode, .failure_active, .pin_is_fail_output,
    .rdata_r, .parity_error_r, .reset_pull_r, .fail_output_r, .window_type_select_r,
    .watchdog_period_select_r, .can_mode_r);

// [verif/mcu_model.sv]
`timescale 1ns/10ps

// Microcontroller side: issues single byte accesses on the falling edge.
module mcu_model (
    // Clock and answer.
    input wire logic       clk,
    input wire logic [7:0] rdata_r,
    input wire logic       parity_error_r,
    // Byte access request.
    output logic           acc_en,
    output logic           acc_write,
    output logic [6:0]     acc_addr,
    output logic [7:0]     acc_wdata
);
    // Idle lines at time zero.
    initial begin
        acc_en = 1'b0;
        acc_write = 1'b0;
        acc_addr = 7'h00;
        acc_wdata = 8'h00;
    end

    // One byte per access; released lines show the inverse of the last value.
    task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d,
                        output logic [7:0] rd, output logic perr);
        @(negedge clk);
        acc_en = 1'b1;
        acc_write = wr;
        acc_addr = a;
        acc_wdata = d;
        @(negedge clk);
        rd = rdata_r;
        perr = parity_error_r;
        acc_en = 1'b0;
        acc_write = ~wr;
        acc_addr = ~a;
        acc_wdata = ~d;
        @(negedge clk);
    endtask

    // Watchdog write with the top bit making the byte even and bit 3 kept zero.
    task automatic wd_write(input logic [6:0] d, output logic perr);
        logic [7:0] rd;
        xfer(1'b1, 7'h03, {^(d & 7'h77), d & 7'h77}, rd, perr);
    endtask
endmodule // mcu_model

// [verif/tb.sv]
`timescale 1ns/10ps

module tb;
    import supply_ctrl_pkg::*;
    logic clk, rst, soft_reset, restart_entry, failsafe_entry, development_mode, lock_a, lock_b;
    logic failure_active, pin_is_fail_output, stop_mode, can_wake_in_stop, acc_en, acc_write;
    logic parity_error_r, reset_pull_r, fail_output_r, charge_pump_enable_r, watchdog_fail_count_select_r;
    logic wdog_off_in_stop_r, window_type_select_r, wdog_wake_start_r, perr, rp;
    logic [1:0] restart_can_mode;
    logic [2:0] watchdog_period_select_r;
    logic [6:0] acc_addr;
    logic [7:0] acc_wdata, rdata_r, rd;
    can_mode_t  can_mode_r;
    int         err_total, checks_done;

    // Inputs at time zero and the clock.
    initial begin
        {clk, soft_reset, restart_entry, failsafe_entry, development_mode, lock_a, lock_b} = 7'h00;
        {failure_active, pin_is_fail_output, stop_mode, can_wake_in_stop, restart_can_mode} = 6'h00;
        rst = 1'b1;
        err_total = 0;
        checks_done = 0;
    end
    always #50 clk = ~clk;

    supply_ctrl_regs u_supply_ctrl_regs (.clk, .rst, .acc_en, .acc_write, .acc_addr, .acc_wdata,
        .soft_reset, .restart_entry, .failsafe_entry, .restart_can_mode, .development_mode, .lock_a,
        .lock_b, .failure_active, .pin_is_fail_output, .stop_mode, .can_wake_in_stop, .rdata_r,
        .parity_error_r, .reset_pull_r, .fail_output_r, .charge_pump_enable_r, .watchdog_fail_count_select_r,
        .wdog_off_in_stop_r, .window_type_select_r, .wdog_wake_start_r, .watchdog_period_select_r, .can_mode_r);
    mcu_model u_mcu_model (.clk, .rdata_r, .parity_error_r, .acc_en, .acc_write, .acc_addr, .acc_wdata);

    // Compare helpers and one-cycle event pulses.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
        u_mcu_model.xfer(1'b0, a, 8'h00, rd, perr);
        chk(rd, exp);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        u_mcu_model.xfer(1'b1, a, d, rd, perr);
    endtask
    task automatic evt(input logic [2:0] v);
        @(negedge clk);
        {failsafe_entry, restart_entry, soft_reset} = v;
        @(negedge clk);
        {failsafe_entry, restart_entry, soft_reset} = 3'h0;
        rp = reset_pull_r;
        @(negedge clk);
    endtask

    // Scenarios.
    task automatic t_por;
        rdchk(7'h02, 8'h00);
        rdchk(7'h03, 8'h14);
        rdchk(7'h04, 8'h00);
        rdchk(7'h05, 8'h00);
    endtask
    task automatic t_hw;
        pin_is_fail_output = 1'b1;
        wr(7'h02, 8'hff);
        rdchk(7'h02, 8'h65);
        chk({5'h0, charge_pump_enable_r, watchdog_fail_count_select_r, fail_output_r}, 8'h07);
    endtask
    task automatic t_wd;
        stop_mode = 1'b1;
        u_mcu_model.wd_write(7'h50, perr);
        chk({7'h0, wdog_off_in_stop_r}, 8'h01);
        @(negedge clk) can_wake_in_stop = 1'b1;
        @(negedge clk) can_wake_in_stop = 1'b0;
        chk({7'h0, wdog_wake_start_r}, 8'h01);
        u_mcu_model.wd_write(7'h7b, perr);
        chk({4'h0, window_type_select_r, watchdog_period_select_r}, 8'h0b);
        u_mcu_model.xfer(1'b1, 7'h03, 8'hfb, rd, perr);
        chk({7'h0, perr}, 8'h01);
        rdchk(7'h03, 8'hf3);
    endtask
    task automatic t_restart;
        restart_can_mode = 2'h2;
        evt(3'h2);
        chk({7'h0, fail_output_r}, 8'h00);
        rdchk(7'h02, 8'h45);
        rdchk(7'h03, 8'hb4);
        rdchk(7'h04, 8'h02);
    endtask
    task automatic t_fail;
        failure_active = 1'b1;
        wr(7'h02, 8'h65);
        wr(7'h02, 8'h45);
        chk({7'h0, fail_output_r}, 8'h01);
        failure_active = 1'b0;
        repeat (2) @(negedge clk);
        chk({7'h0, fail_output_r}, 8'h00);
    endtask
    task automatic t_lock;
        {lock_a, lock_b} = 2'h3;
        wr(7'h02, 8'h00);
        rdchk(7'h02, 8'h44);
        evt(3'h1);
        chk({7'h0, rp}, 8'h00);
        rdchk(7'h02, 8'h44);
        {lock_a, lock_b, development_mode} = 3'h1;
        wr(7'h02, 8'h00);
        evt(3'h1);
        chk({7'h0, rp}, 8'h01);
        rdchk(7'h04, 8'h03);
    endtask
    task automatic t_bus;
        for (int i = 0; i < 4; i++) begin
            wr(7'h04, {6'h3f, i[1:0]});
            chk({6'h0, can_mode_r}, {6'h0, i[1:0]});
        end
        evt(3'h4);
        rdchk(7'h04, 8'h01);
    endtask

    // Verdict and end of run.
    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Main sequence.
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        t_por;
        t_hw;
        t_wd;
        t_restart;
        t_fail;
        t_lock;
        t_bus;
        complete_run;
    end

    // Watchdog against a hang.
    initial begin
        #1000000;
        err_total++;
        $display("ERROR %0t: timeout", $time);
        complete_run;
    end
endmodule // tb
